// ===== design/cid_pkg.sv
/*
 * Shared types and constants for the execute slice of the small 8-bit core:
 * opcodes, instruction and result carriers, widths and reset values.
 * Assumes the decoder upstream has already mapped raw opcodes onto cid_op_t.
 */
package cid_pkg;
	localparam int CID_DATA_W = 8;
	localparam int CID_ADDR_W = 5;
	localparam int CID_LIT_W = 9;
	localparam int CID_PC_W = 11;
	localparam int CID_STATUS_W = 8;
	localparam int CID_PAGE_HI = 6;
	localparam int CID_PAGE_LO = 5;
	localparam logic [7:0] CID_ACC_RST = 8'h00;
	localparam logic CID_ZERO_RST = 1'b0;
	localparam logic [7:0] CID_ONE = 8'h01;
	localparam logic [7:0] CID_ALL_ZERO = 8'h00;
	localparam logic CID_DEST_ACC = 1'b0;
	localparam logic CID_DEST_FILE = 1'b1;
	localparam int CID_NOP_CYCLES = 1;

	typedef enum logic [3:0] {
		CID_OP_NONE = 4'h0,
		CID_OP_DECREMENT_FILE = 4'h1,
		CID_OP_DECREMENT_SKIP_ZERO = 4'h2,
		CID_OP_INCREMENT_FILE = 4'h3,
		CID_OP_INCREMENT_SKIP_ZERO = 4'h4,
		CID_OP_JUMP_IMMEDIATE = 4'h5,
		CID_OP_OR_LITERAL_ACCUM = 4'h6,
		CID_OP_OR_ACCUM_FILE = 4'h7,
		CID_OP_STORE_ACCUM_FILE = 4'h8
	} cid_op_t;

	typedef enum logic [1:0] {
		CID_ST_RUN = 2'b01,
		CID_ST_NOP = 2'b10
	} cid_state_t;

	typedef struct packed {
		cid_op_t op;
		logic [CID_ADDR_W-1:0] fileAddr;
		logic destSel;
		logic [CID_LIT_W-1:0] literal;
	} cid_instr_t;

	typedef struct packed {
		logic en;
		logic [CID_ADDR_W-1:0] addr;
		logic [CID_DATA_W-1:0] data;
	} cid_fwrite_t;

	typedef struct packed {
		logic load;
		logic [CID_PC_W-1:0] target;
	} cid_pcload_t;

	typedef struct packed {
		logic upd;
		logic val;
	} cid_zero_t;
endpackage

// ===== design/cid_alu.sv
/*
 * Combinational datapath: inc, dec, inclusive or and pass-through of the
 * accumulator, with zero detection and the skip decision.
 * Assumes operands are stable for the cycle in which the op is accepted.
 */
`timescale 1ns/1ns
module cid_alu
	import cid_pkg::*;
(
	input wire cid_op_t op,
	input wire logic [7:0] accum,
	input wire logic [7:0] fileData,
	input wire logic [7:0] literal8,
	output logic [7:0] result,
	output logic zeroUpd,
	output logic resultZero,
	output logic skipZero
);
	wire logic [7:0] incVal;
	wire logic [7:0] decVal;
	wire logic isDec;
	wire logic isInc;
	wire logic isOrLit;
	wire logic isOrFile;

	// 8-bit wrap, no carry or borrow is produced
	assign incVal = 8'(fileData + CID_ONE); // see (RULE13)
	assign decVal = 8'(fileData - CID_ONE); // see (RULE13)
	assign isDec = (op == CID_OP_DECREMENT_FILE) ||
		(op == CID_OP_DECREMENT_SKIP_ZERO);
	assign isInc = (op == CID_OP_INCREMENT_FILE) ||
		(op == CID_OP_INCREMENT_SKIP_ZERO);
	assign isOrLit = (op == CID_OP_OR_LITERAL_ACCUM);
	assign isOrFile = (op == CID_OP_OR_ACCUM_FILE);
	assign result = isDec ? decVal : // see (RULE1)
		isInc ? incVal : // see (RULE4)
		isOrLit ? (accum | literal8) : // see (RULE9)
		isOrFile ? (accum | fileData) : // see (RULE10)
		accum; // see (RULE11)
	assign resultZero = (result == CID_ALL_ZERO); // see (RULE12)
	// skip variants and the store leave every flag alone
	assign zeroUpd = (op == CID_OP_DECREMENT_FILE) || // see (RULE2)
		(op == CID_OP_INCREMENT_FILE) || isOrLit || isOrFile;
	assign skipZero = resultZero && // see (RULE3)
		((op == CID_OP_DECREMENT_SKIP_ZERO) ||
		(op == CID_OP_INCREMENT_SKIP_ZERO)); // see (RULE5)
endmodule

// ===== design/cid_pc_build.sv
/*
 * Forms the paged jump target from the 9-bit immediate and the page
 * select bits of the status register.
 * Assumes status is the live status register value.
 */
`timescale 1ns/1ns
module cid_pc_build
	import cid_pkg::*;
(
	input wire logic [CID_LIT_W-1:0] literal,
	input wire logic [CID_STATUS_W-1:0] status,
	output logic [CID_PC_W-1:0] target
);
	assign target = {status[CID_PAGE_HI:CID_PAGE_LO], // see (RULE7)
		literal}; // see (RULE6)
endmodule

// ===== design/cid_exec.sv
/*
 * Execute slice for inc/dec (with skip), paged jump, inclusive or and
 * accumulator store. Owns the accumulator and a copy of the zero flag.
 * Assumes the fetch unit presents one decoded instruction with the
 * addressed file register already read, honours instrReady, and drops
 * its prefetched word whenever discardFetch pulses.
 */
`timescale 1ns/1ns

// Notes on behaviour
// (RULE1) decrement file: f minus one to accumulator or file, zero flag set.
// (RULE2) decrement-skip: f minus one routed by destination, no flag change.
// (RULE3) decrement-skip zero result: drop prefetched word, run nop, two cycles.
// (RULE4) increment file: f plus one to accumulator or file, zero flag set.
// (RULE5) increment-skip: route sum, on zero drop prefetch and run nop.
// (RULE6) jump loads 9-bit immediate into pc bits 8 to 0.
// (RULE7) jump copies status bits 6 and 5 into pc bits 10 and 9.
// (RULE8) jump always taken, two cycles, no status bit touched.
// (RULE9) or literal: accumulator or 8-bit literal into accumulator, zero flag.
// (RULE10) or file: accumulator or f routed by destination, zero flag set.
// (RULE11) store accumulator into addressed file register, no flag change.
// (RULE12) zero flag set for all-zero result, cleared otherwise.
// (RULE13) increment and decrement wrap modulo 256, no carry or borrow.
module cid_exec
	import cid_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic instrValid,
	input wire cid_instr_t instrIn,
	input wire logic [CID_DATA_W-1:0] fileRdData,
	input wire logic [CID_STATUS_W-1:0] statusIn,
	output logic instrReady,
	output logic [CID_DATA_W-1:0] accumOut,
	output cid_zero_t zeroOut,
	output cid_fwrite_t fileWrOut,
	output cid_pcload_t pcLoadOut,
	output logic discardFetch
);
	cid_state_t stateReg;
	cid_state_t stateNext;
	logic readyReg;
	logic [7:0] accReg;
	logic [7:0] accNext;
	cid_zero_t zeroReg;
	cid_zero_t zeroNext;
	cid_fwrite_t fileWrReg;
	cid_fwrite_t fileWrNext;
	cid_pcload_t pcReg;
	cid_pcload_t pcNext;
	logic discardReg;
	logic discardNext;

	wire logic accept;
	wire logic isJump;
	wire logic isStore;
	wire logic isOrLit;
	wire logic fileOp;
	wire logic toFile;
	wire logic toAcc;
	wire logic twoCycle;
	wire logic [7:0] aluResult;
	wire logic aluZeroUpd;
	wire logic aluZero;
	wire logic aluSkip;
	wire logic [CID_PC_W-1:0] jumpTarget;

	cid_alu uAlu (
		.op(instrIn.op),
		.accum(accReg),
		.fileData(fileRdData),
		.literal8(instrIn.literal[CID_DATA_W-1:0]),
		.result(aluResult),
		.zeroUpd(aluZeroUpd),
		.resultZero(aluZero),
		.skipZero(aluSkip)
	);

	cid_pc_build uPc (
		.literal(instrIn.literal),
		.status(statusIn),
		.target(jumpTarget)
	);

	// nothing is taken while the nop slot of a two-cycle op runs
	assign accept = instrValid && (stateReg == CID_ST_RUN);
	assign isJump = (instrIn.op == CID_OP_JUMP_IMMEDIATE);
	assign isStore = (instrIn.op == CID_OP_STORE_ACCUM_FILE);
	assign isOrLit = (instrIn.op == CID_OP_OR_LITERAL_ACCUM);
	assign fileOp = (instrIn.op == CID_OP_DECREMENT_FILE) ||
		(instrIn.op == CID_OP_DECREMENT_SKIP_ZERO) ||
		(instrIn.op == CID_OP_INCREMENT_FILE) ||
		(instrIn.op == CID_OP_INCREMENT_SKIP_ZERO) ||
		(instrIn.op == CID_OP_OR_ACCUM_FILE);
	// destination routing by destSel; store always targets the file
	assign toFile = (fileOp && (instrIn.destSel == CID_DEST_FILE)) ||
		isStore; // see (RULE11)
	assign toAcc = (fileOp && (instrIn.destSel == CID_DEST_ACC)) ||
		isOrLit; // see (RULE9)
	assign twoCycle = isJump || aluSkip; // see (RULE8)

	assign accNext = (accept && toAcc) ? aluResult : accReg; // see (RULE1)
	assign fileWrNext.en = accept && toFile; // see (RULE10)
	assign fileWrNext.addr = instrIn.fileAddr;
	assign fileWrNext.data = aluResult; // see (RULE4)
	assign zeroNext.upd = accept && aluZeroUpd; // see (RULE2)
	assign zeroNext.val = zeroNext.upd ? aluZero : zeroReg.val; // see (RULE12)
	assign pcNext.load = accept && isJump; // see (RULE6)
	assign pcNext.target = pcNext.load ? jumpTarget : pcReg.target;
	assign discardNext = accept && twoCycle; // see (RULE3)

	always_comb begin
		case (stateReg)
			CID_ST_RUN: begin
				stateNext = discardNext ? CID_ST_NOP : CID_ST_RUN; // see (RULE5)
			end
			CID_ST_NOP: begin
				// exactly one nop slot follows a skip or a jump
				stateNext = CID_ST_RUN;
			end
			default: begin
				stateNext = CID_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			stateReg <= CID_ST_RUN;
			readyReg <= 1'b1;
			discardReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			readyReg <= (stateNext == CID_ST_RUN);
			discardReg <= discardNext;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			accReg <= CID_ACC_RST;
			zeroReg <= '{upd: 1'b0, val: CID_ZERO_RST};
		end else begin
			accReg <= accNext;
			zeroReg <= zeroNext;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			fileWrReg <= '0;
			pcReg <= '0;
		end else begin
			fileWrReg <= fileWrNext;
			pcReg <= pcNext;
		end
	end

	assign instrReady = readyReg;
	assign accumOut = accReg;
	assign zeroOut = zeroReg;
	assign fileWrOut = fileWrReg;
	assign pcLoadOut = pcReg;
	assign discardFetch = discardReg;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_DEC_TO_ACC: assert property ( // see (RULE1)
		accept && instrIn.op == CID_OP_DECREMENT_FILE && !instrIn.destSel
		|=> accReg == 8'($past(fileRdData) - 8'h01) && zeroReg.upd
			&& !fileWrReg.en)
		else $error("decrement to accumulator wrong");

	AST_DECSZ_NO_FLAG: assert property ( // see (RULE2)
		accept && instrIn.op == CID_OP_DECREMENT_SKIP_ZERO && instrIn.destSel
		|=> !zeroReg.upd && $stable(zeroReg.val) && fileWrReg.en
			&& fileWrReg.data == 8'($past(fileRdData) - 8'h01))
		else $error("decrement-skip touched flag or lost result");

	AST_DECSZ_SKIP: assert property ( // see (RULE3)
		accept && instrIn.op == CID_OP_DECREMENT_SKIP_ZERO
			&& fileRdData == 8'h01
		|=> discardReg && !readyReg ##1 !discardReg && readyReg)
		else $error("zero decrement-skip did not run one nop");

	AST_DECSZ_NOSKIP: assert property ( // see (RULE3)
		accept && instrIn.op == CID_OP_DECREMENT_SKIP_ZERO
			&& fileRdData != 8'h01
		|=> !discardReg && readyReg)
		else $error("nonzero decrement-skip skipped");

	AST_INC_TO_FILE: assert property ( // see (RULE4)
		accept && instrIn.op == CID_OP_INCREMENT_FILE && instrIn.destSel
		|=> fileWrReg.en && fileWrReg.addr == $past(instrIn.fileAddr)
			&& fileWrReg.data == 8'($past(fileRdData) + 8'h01)
			&& zeroReg.upd && $stable(accReg))
		else $error("increment to file wrong");

	AST_INCSZ_SKIP: assert property ( // see (RULE5)
		accept && instrIn.op == CID_OP_INCREMENT_SKIP_ZERO
			&& fileRdData == 8'hff && !instrIn.destSel
		|=> discardReg && accReg == 8'h00 && !zeroReg.upd
			##1 readyReg)
		else $error("zero increment-skip wrong");

	AST_JUMP_TARGET: assert property ( // see (RULE6)
		accept && isJump
		|=> pcReg.load && pcReg.target[8:0] == $past(instrIn.literal))
		else $error("jump low target wrong");

	AST_JUMP_PAGE: assert property ( // see (RULE7)
		accept && isJump
		|=> pcReg.target[10:9] == $past(statusIn[6:5]))
		else $error("jump page bits wrong");

	AST_JUMP_TWO: assert property ( // see (RULE8)
		accept && isJump
		|=> discardReg && !readyReg && !zeroReg.upd && !fileWrReg.en
			##1 readyReg && !pcReg.load)
		else $error("jump not a flag-free two-cycle op");

	AST_NOP_SLOT_IDLE: assert property ( // see (RULE8)
		stateReg == CID_ST_NOP
		|=> !fileWrReg.en && !zeroReg.upd && !pcReg.load && $stable(accReg))
		else $error("nop slot had side effects");

	AST_OR_LIT: assert property ( // see (RULE9)
		accept && isOrLit
		|=> accReg == ($past(accReg) | $past(instrIn.literal[7:0]))
			&& zeroReg.upd && !fileWrReg.en)
		else $error("or literal wrong");

	AST_OR_FILE: assert property ( // see (RULE10)
		accept && instrIn.op == CID_OP_OR_ACCUM_FILE && instrIn.destSel
		|=> fileWrReg.en
			&& fileWrReg.data == ($past(accReg) | $past(fileRdData))
			&& zeroReg.upd)
		else $error("or file wrong");

	AST_STORE: assert property ( // see (RULE11)
		accept && isStore
		|=> fileWrReg.en && fileWrReg.data == $past(accReg)
			&& !zeroReg.upd && $stable(accReg))
		else $error("store accumulator wrong");

	AST_ZERO_SENSE: assert property ( // see (RULE12)
		zeroReg.upd && fileWrReg.en
		|-> zeroReg.val == (fileWrReg.data == 8'h00))
		else $error("zero flag disagrees with file result");

	AST_ZERO_SENSE_ACC: assert property ( // see (RULE12)
		zeroReg.upd && !fileWrReg.en
		|-> zeroReg.val == (accReg == 8'h00))
		else $error("zero flag disagrees with accumulator");

	AST_DEC_WRAP: assert property ( // see (RULE13)
		accept && instrIn.op == CID_OP_DECREMENT_FILE
			&& fileRdData == 8'h00 && !instrIn.destSel
		|=> accReg == 8'hff && !zeroReg.val)
		else $error("decrement did not wrap");

	CVR_SKIP: cover property (
		accept && instrIn.op == CID_OP_INCREMENT_SKIP_ZERO
			&& fileRdData == 8'hff ##1 discardReg);
	CVR_JUMP: cover property (accept && isJump ##2 accept);
	CVR_OR_ZERO: cover property (zeroReg.upd && zeroReg.val);
	CVR_BACK_TO_BACK: cover property (accept ##1 accept ##1 accept);
endmodule

// ===== tb/cid_file_model.sv
/*
 * File register space model facing the execute slice.
 * Assumes the bench preloads registers only while no write is in flight.
 */
`timescale 1ns/1ns
module cid_file_model
	import cid_pkg::*;
(
	input wire logic clk,
	input wire logic [CID_ADDR_W-1:0] rdAddr,
	input wire cid_fwrite_t fileWr,
	input wire logic preEn,
	input wire logic [CID_ADDR_W-1:0] preAddr,
	input wire logic [CID_DATA_W-1:0] preData,
	output logic [CID_DATA_W-1:0] rdData
);
	logic [CID_DATA_W-1:0] mem [0:31];
	wire logic fwdHit;
	// forward the write in flight, the slice does not
	assign fwdHit = fileWr.en && fileWr.addr == rdAddr;
	assign rdData = fwdHit ? fileWr.data : mem[rdAddr];
	always_ff @(posedge clk) begin
		if (fileWr.en)
			mem[fileWr.addr] <= fileWr.data;
		else if (preEn)
			mem[preAddr] <= preData;
	end
endmodule

// ===== tb/test_cid_exec.sv
/*
 * Self-checking bench for the execute slice: corner cases, then random ops.
 * Assumes the file model above stands in for fetch unit and file space.
 */
`timescale 1ns/1ns
module test_cid_exec
	import cid_pkg::*;
;
	logic clk = 0, rstn = 0, instrValid = 0, preEn = 0;
	cid_instr_t instrIn = '0;
	logic [7:0] fileRdData, statusIn = 8'h00, preData = 8'h00;
	logic [4:0] preAddr = 5'h00;
	logic instrReady, discardFetch;
	logic [7:0] accumOut;
	cid_zero_t zeroOut;
	cid_fwrite_t fileWrOut;
	cid_pcload_t pcLoadOut;
	int bad_count = 0, compares = 0;
	logic [7:0] mAcc = 8'h00, mFile [0:31];
	logic mZero = 1'b0;
	logic [10:0] mTarget = 11'h000;

	always #5 clk = ~clk;

	cid_exec u_cid_exec (.clk(clk), .rstn(rstn), .instrValid(instrValid),
		.instrIn(instrIn), .fileRdData(fileRdData), .statusIn(statusIn),
		.instrReady(instrReady), .accumOut(accumOut), .zeroOut(zeroOut),
		.fileWrOut(fileWrOut), .pcLoadOut(pcLoadOut),
		.discardFetch(discardFetch));
	cid_file_model u_cid_file_model (.clk(clk), .rdAddr(instrIn.fileAddr),
		.fileWr(fileWrOut), .preEn(preEn), .preAddr(preAddr),
		.preData(preData), .rdData(fileRdData));

	task test_done;
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, nm, got, exp);
		end
	endtask

	function logic [7:0] expRes(cid_op_t op, logic [7:0] f, logic [7:0] acc,
		logic [8:0] lit);
		case (op)
			CID_OP_DECREMENT_FILE, CID_OP_DECREMENT_SKIP_ZERO: return f - 8'h01;
			CID_OP_INCREMENT_FILE, CID_OP_INCREMENT_SKIP_ZERO: return f + 8'h01;
			CID_OP_OR_LITERAL_ACCUM: return acc | lit[7:0];
			CID_OP_OR_ACCUM_FILE: return acc | f;
			default: return acc;
		endcase
	endfunction

	task preload(input logic [4:0] a, input logic [7:0] v);
		preEn = 1;
		preAddr = a;
		preData = v;
		mFile[a] = v;
		@(posedge clk);
		#1;
	endtask

	task run(input cid_op_t op, input logic [4:0] a, input logic d,
		input logic [8:0] lit, input logic [7:0] st);
		logic [7:0] r;
		logic dOp, wrF, wrA, zu, jmp, stall;
		statusIn = st;
		instrIn = '{op, a, d, lit};
		instrValid = 1;
		r = expRes(op, mFile[a], mAcc, lit);
		dOp = op inside {CID_OP_DECREMENT_FILE, CID_OP_DECREMENT_SKIP_ZERO,
			CID_OP_INCREMENT_FILE, CID_OP_INCREMENT_SKIP_ZERO,
			CID_OP_OR_ACCUM_FILE};
		wrF = (dOp && d) || op == CID_OP_STORE_ACCUM_FILE;
		wrA = (dOp && !d) || op == CID_OP_OR_LITERAL_ACCUM;
		zu = op inside {CID_OP_DECREMENT_FILE, CID_OP_INCREMENT_FILE,
			CID_OP_OR_LITERAL_ACCUM, CID_OP_OR_ACCUM_FILE};
		jmp = op == CID_OP_JUMP_IMMEDIATE;
		stall = jmp || (r == 8'h00 && op inside {CID_OP_DECREMENT_SKIP_ZERO,
			CID_OP_INCREMENT_SKIP_ZERO});
		@(posedge clk);
		#1;
		if (wrA)
			mAcc = r;
		if (wrF)
			mFile[a] = r;
		if (zu)
			mZero = r == 8'h00;
		if (jmp)
			mTarget = {st[6:5], lit};
		chk("fwen", fileWrOut.en, wrF);
		if (wrF)
			chk("fwdat", {fileWrOut.addr, fileWrOut.data}, {a, r});
		chk("acc", accumOut, mAcc);
		chk("zero", zeroOut, {zu, mZero});
		chk("pc", pcLoadOut, {jmp, mTarget});
		chk("skip", {discardFetch, instrReady}, {stall, !stall});
		if (stall) begin
			// offered in the nop slot, must be ignored
			instrIn.op = CID_OP_STORE_ACCUM_FILE;
			@(posedge clk);
			#1;
			chk("nop", {fileWrOut.en, discardFetch, instrReady, pcLoadOut.load},
				4'b0010);
		end
	endtask

	initial begin
		#20000;
		bad_count++;
		test_done();
	end

	initial begin
		void'($urandom(81));
		repeat (20) @(posedge clk);
		#1;
		chk("reset", {instrReady, accumOut, zeroOut, fileWrOut.en,
			pcLoadOut.load, discardFetch}, 14'h2000);
		rstn = 1;
		for (int i = 0; i < 32; i++)
			preload(5'(i), 8'($urandom));
		preload(5'h03, 8'hff);
		preload(5'h04, 8'h01);
		preload(5'h05, 8'h00);
		preEn = 0;
		run(CID_OP_INCREMENT_SKIP_ZERO, 5'h03, 1'b0, 9'h000, 8'h00);
		run(CID_OP_OR_LITERAL_ACCUM, 5'h00, 1'b0, 9'h100, 8'h00);
		run(CID_OP_INCREMENT_SKIP_ZERO, 5'h03, 1'b1, 9'h000, 8'h00);
		run(CID_OP_DECREMENT_SKIP_ZERO, 5'h04, 1'b1, 9'h000, 8'h00);
		run(CID_OP_DECREMENT_SKIP_ZERO, 5'h04, 1'b1, 9'h000, 8'h00);
		run(CID_OP_OR_ACCUM_FILE, 5'h05, 1'b1, 9'h000, 8'h00);
		run(CID_OP_DECREMENT_FILE, 5'h05, 1'b0, 9'h000, 8'h00);
		run(CID_OP_INCREMENT_FILE, 5'h03, 1'b1, 9'h000, 8'h00);
		run(CID_OP_JUMP_IMMEDIATE, 5'h00, 1'b0, 9'h1ff, 8'h60);
		run(CID_OP_JUMP_IMMEDIATE, 5'h00, 1'b0, 9'h0a5, 8'hbf);
		run(CID_OP_STORE_ACCUM_FILE, 5'h1f, 1'b0, 9'h000, 8'h00);
		run(CID_OP_NONE, 5'h02, 1'b1, 9'h000, 8'h00);
		// few addresses so read-after-write back to back is frequent
		for (int i = 0; i < 300; i++)
			run(cid_op_t'($urandom_range(8, 0)), 5'($urandom_range(7, 0)),
				1'($urandom), 9'($urandom), 8'($urandom));
		instrValid = 0;
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule
